// *** verilog/peripheral_irq_enable_flag_bank.sv ***
/*
  Peripheral interrupt enable and flag bank: one enable byte, one flag byte and a combined request.
  Assumes event inputs are one-cycle pulses from logic on clk, and a byte register port.
*/
// The address-and-strobe port was chosen for this implementation.
// How it works
// RL1: Flags latch on their event regardless of per-source or global enables.
// RL2: Software should clear a flag before enabling its source.
// RL3: Enable bit 7 gates the parallel port read/write request.
// RL4: Enable bit 5 gates the serial receive request.
// RL5: Enable bit 4 gates the serial transmit request.
// RL6: Enable bit 1 gates the second timer period match request.
// RL7: Enable bit 0 gates the first timer overflow request.
// RL8: Software writes zero to reserved upper flag bits in portless variant.
// RL9: Without the serial unit, flag bits 5 and 4 read zero.
// RL10: Flag bit 3 sets on sync serial transfer done, held until cleared.
// RL11: In capture mode, flag bit 2 sets on a capture, held until cleared.
// RL12: In compare mode, flag bit 2 sets on a match, held until cleared.
// RL13: In pulse-width mode the unit never sets flag bit 2.
// RL14: Flag bit 1 sets on second timer period match, held until cleared.
// RL15: Flag bit 0 sets on first timer overflow, held until cleared.
// RL16: Receive flag reads one while receive buffer holds data.
// RL17: Transmit flag reads one while transmit buffer is empty.
// RL18: Receive and transmit flags are read-only; others read and write.
// RL19: All enable and flag bits reset to zero.
// RL20: Global enable at control bit 7 gates every peripheral request.
// RL21: Combined request is high when any flag and its enable are both one.
`timescale 1ns/1ps
module peripheral_irq_enable_flag_bank #(
  parameter bit HAS_PARALLEL = 1'b1,
  parameter bit HAS_SERIAL   = 1'b1
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Register port.
  input  wire logic [7:0]                  addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [7:0]                  rdata,
  // Peripheral events and states.
  input  wire logic                        parallel_rw_event,
  input  wire logic                        sync_serial_done,
  input  wire logic                        capcmp_capture,
  input  wire logic                        capcmp_match,
  input  wire irq_bank_pkg::capcmp_mode_t  capcmp_mode,
  input  wire logic                        timer_b_match,
  input  wire logic                        timer_a_overflow,
  input  wire logic                        serial_rx_full,
  input  wire logic                        serial_tx_empty,
  // Combined request to the core.
  output logic                             periph_irq
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic       global_irq_en;
    logic [7:0] rdata;
    logic       irq;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic [7:0] set_vec;
  logic [7:0] live_flags;
  logic [7:0] impl_mask;

  // Stored flag bits: the reserved bit and both buffer-state bits never hold a one.
  localparam logic [7:0] FLAG_STORE_MASK = ~(8'(1 << irq_bank_pkg::RESERVED_BIT) |
                                            8'(1 << irq_bank_pkg::RX_BIT) |
                                            8'(1 << irq_bank_pkg::TX_BIT));

  // Bits that exist in this variant; the reserved bit never holds a one.
  always_comb begin
    impl_mask = 8'h0f;
    impl_mask[irq_bank_pkg::PARALLEL_BIT] = HAS_PARALLEL;
    impl_mask[irq_bank_pkg::RX_BIT]       = HAS_SERIAL;   // [RL9]
    impl_mask[irq_bank_pkg::TX_BIT]       = HAS_SERIAL;   // [RL9]
  end

  // Event set vector; capture/compare qualified by its mode.
  always_comb begin
    set_vec = 8'h00;
    set_vec[irq_bank_pkg::PARALLEL_BIT] = parallel_rw_event;
    set_vec[irq_bank_pkg::SYNC_BIT]     = sync_serial_done;                     // [RL10]
    set_vec[irq_bank_pkg::CAPCMP_BIT]   =
      (capcmp_mode == irq_bank_pkg::CC_CAPTURE && capcmp_capture) ||            // [RL11]
      (capcmp_mode == irq_bank_pkg::CC_COMPARE && capcmp_match);                // [RL12] [RL13]
    set_vec[irq_bank_pkg::TIMER_B_BIT]  = timer_b_match;                        // [RL14]
    set_vec[irq_bank_pkg::TIMER_A_BIT]  = timer_a_overflow;                     // [RL15]
  end

  // Flag byte as seen by software and the request logic.
  always_comb begin
    live_flags = state_ff.flags;
    live_flags[irq_bank_pkg::RX_BIT] = serial_rx_full;   // [RL16]
    live_flags[irq_bank_pkg::TX_BIT] = serial_tx_empty;  // [RL17]
    live_flags = live_flags & impl_mask;                 // [RL9]
  end

  // Next-state logic: writes first, then events, so a set wins over a clear.
  always_comb begin
    nxt_state = state_ff;
    if (wr && addr == irq_bank_pkg::FLAGS_OFFSET) begin
      // Serial bits stay read-only; they follow the buffer state.
      nxt_state.flags = wdata & impl_mask & FLAG_STORE_MASK;  // [RL18]
    end
    if (wr && addr == irq_bank_pkg::ENABLES_OFFSET) begin
      nxt_state.enables = wdata & impl_mask;
    end
    if (wr && addr == irq_bank_pkg::CONTROL_OFFSET) begin
      nxt_state.global_irq_en = wdata[irq_bank_pkg::GLOBAL_BIT];
    end
    nxt_state.flags = (nxt_state.flags | set_vec) & impl_mask & FLAG_STORE_MASK;  // [RL1]
    nxt_state.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        irq_bank_pkg::FLAGS_OFFSET:   nxt_state.rdata = live_flags;
        irq_bank_pkg::ENABLES_OFFSET: nxt_state.rdata = state_ff.enables;
        irq_bank_pkg::CONTROL_OFFSET: nxt_state.rdata = {state_ff.global_irq_en, 7'h00};
        default:                      nxt_state.rdata = 8'h00;
      endcase
    end
    // Per-source gating then global gating.
    nxt_state.irq = state_ff.global_irq_en && |(live_flags & state_ff.enables);  // [RL3] [RL4] [RL5] [RL6] [RL7] [RL20] [RL21]
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;  // [RL19]
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata      = state_ff.rdata;
  assign periph_irq = state_ff.irq;

  // ==========================================================================
  // Assertions.
  // Decoded write strobes and gated flags, used only by the checks below.
  logic       flag_wr;
  logic       en_wr;
  logic       ctl_wr;
  logic [7:0] pending;
  assign flag_wr = wr && addr == irq_bank_pkg::FLAGS_OFFSET;
  assign en_wr   = wr && addr == irq_bank_pkg::ENABLES_OFFSET;
  assign ctl_wr  = wr && addr == irq_bank_pkg::CONTROL_OFFSET;
  assign pending = live_flags & state_ff.enables;

  property p_flag_latch;
    @(posedge clk) disable iff (reset) timer_a_overflow |=> state_ff.flags[irq_bank_pkg::TIMER_A_BIT];
  endproperty
  a_flag_latch: assert property (p_flag_latch) else $error("Overflow flag not latched."); // [RL1] [RL15]

  property p_sync_hold;
    @(posedge clk) disable iff (reset)
      state_ff.flags[irq_bank_pkg::SYNC_BIT] && !(wr && addr == irq_bank_pkg::FLAGS_OFFSET)
      |=> state_ff.flags[irq_bank_pkg::SYNC_BIT];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("Sync flag dropped without write."); // [RL10]

  property p_capture;
    @(posedge clk) disable iff (reset)
      capcmp_mode == irq_bank_pkg::CC_CAPTURE && capcmp_capture |=> state_ff.flags[irq_bank_pkg::CAPCMP_BIT];
  endproperty
  a_capture: assert property (p_capture) else $error("Capture did not set flag."); // [RL11]

  property p_compare;
    @(posedge clk) disable iff (reset)
      capcmp_mode == irq_bank_pkg::CC_COMPARE && capcmp_match |=> state_ff.flags[irq_bank_pkg::CAPCMP_BIT];
  endproperty
  a_compare: assert property (p_compare) else $error("Compare did not set flag."); // [RL12]

  property p_pwm_quiet;
    @(posedge clk) disable iff (reset)
      capcmp_mode == irq_bank_pkg::CC_PULSE_WIDTH && !state_ff.flags[irq_bank_pkg::CAPCMP_BIT]
      && !(wr && addr == irq_bank_pkg::FLAGS_OFFSET) |=> !state_ff.flags[irq_bank_pkg::CAPCMP_BIT];
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("Pulse-width mode set the flag."); // [RL13]

  property p_timer_b;
    @(posedge clk) disable iff (reset) timer_b_match |=> state_ff.flags[irq_bank_pkg::TIMER_B_BIT];
  endproperty
  a_timer_b: assert property (p_timer_b) else $error("Timer match flag not set."); // [RL14]

  property p_rx_read;
    @(posedge clk) disable iff (reset) rd && addr == irq_bank_pkg::FLAGS_OFFSET |=>
      rdata[irq_bank_pkg::RX_BIT] == (HAS_SERIAL && $past(serial_rx_full));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("Receive flag read wrong."); // [RL16] [RL9]

  property p_tx_read;
    @(posedge clk) disable iff (reset) rd && addr == irq_bank_pkg::FLAGS_OFFSET |=>
      rdata[irq_bank_pkg::TX_BIT] == (HAS_SERIAL && $past(serial_tx_empty));
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("Transmit flag read wrong."); // [RL17] [RL18]

  property p_irq;
    @(posedge clk) disable iff (reset)
      1'b1 |=> periph_irq == ($past(state_ff.global_irq_en) && |($past(live_flags) & $past(state_ff.enables)));
  endproperty
  a_irq: assert property (p_irq) else $error("Combined request wrong."); // [RL20] [RL21] [RL3] [RL7]

  property p_no_gate_global;
    @(posedge clk) disable iff (reset) !state_ff.global_irq_en |=> !periph_irq;
  endproperty
  a_no_gate_global: assert property (p_no_gate_global) else $error("Request with global enable low."); // [RL20]

  property p_parallel_latch;
    @(posedge clk) disable iff (reset)
      HAS_PARALLEL && parallel_rw_event |=> state_ff.flags[irq_bank_pkg::PARALLEL_BIT];
  endproperty
  a_parallel_latch: assert property (p_parallel_latch) else $error("Parallel port flag not latched."); // [RL1]

  property p_sync_latch;
    @(posedge clk) disable iff (reset)
      sync_serial_done |=> state_ff.flags[irq_bank_pkg::SYNC_BIT];
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("Sync flag not latched."); // [RL10]

  property p_timer_a_hold;
    @(posedge clk) disable iff (reset)
      state_ff.flags[irq_bank_pkg::TIMER_A_BIT] && !flag_wr |=> state_ff.flags[irq_bank_pkg::TIMER_A_BIT];
  endproperty
  a_timer_a_hold: assert property (p_timer_a_hold) else $error("Overflow flag dropped without write."); // [RL15]

  property p_timer_b_hold;
    @(posedge clk) disable iff (reset)
      state_ff.flags[irq_bank_pkg::TIMER_B_BIT] && !flag_wr |=> state_ff.flags[irq_bank_pkg::TIMER_B_BIT];
  endproperty
  a_timer_b_hold: assert property (p_timer_b_hold) else $error("Match flag dropped without write."); // [RL14]

  property p_capcmp_hold;
    @(posedge clk) disable iff (reset)
      state_ff.flags[irq_bank_pkg::CAPCMP_BIT] && !flag_wr |=> state_ff.flags[irq_bank_pkg::CAPCMP_BIT];
  endproperty
  a_capcmp_hold: assert property (p_capcmp_hold) else $error("Capture flag dropped without write."); // [RL11] [RL12]

  property p_flag_write;
    @(posedge clk) disable iff (reset)
      flag_wr && set_vec == 8'h00 |=> state_ff.flags == ($past(wdata) & impl_mask & FLAG_STORE_MASK);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("Flag write stored wrong value."); // [RL18]

  property p_serial_ro;
    @(posedge clk) disable iff (reset)
      1'b1 |-> !state_ff.flags[irq_bank_pkg::RX_BIT] && !state_ff.flags[irq_bank_pkg::TX_BIT];
  endproperty
  a_serial_ro: assert property (p_serial_ro) else $error("Buffer flag bit was stored."); // [RL18]

  property p_flag_reserved;
    @(posedge clk) disable iff (reset)
      1'b1 |-> !state_ff.flags[irq_bank_pkg::RESERVED_BIT];
  endproperty
  a_flag_reserved: assert property (p_flag_reserved) else $error("Reserved flag bit was stored.");

  property p_enable_reserved;
    @(posedge clk) disable iff (reset)
      1'b1 |-> !state_ff.enables[irq_bank_pkg::RESERVED_BIT];
  endproperty
  a_enable_reserved: assert property (p_enable_reserved) else $error("Reserved enable bit was stored.");

  property p_enable_write;
    @(posedge clk) disable iff (reset)
      en_wr |=> state_ff.enables == ($past(wdata) & impl_mask);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("Enable write stored wrong value.");

  property p_control_set;
    @(posedge clk) disable iff (reset)
      ctl_wr && wdata[irq_bank_pkg::GLOBAL_BIT] |=> state_ff.global_irq_en;
  endproperty
  a_control_set: assert property (p_control_set) else $error("Global enable not set by write."); // [RL20]

  property p_control_clear;
    @(posedge clk) disable iff (reset)
      ctl_wr && !wdata[irq_bank_pkg::GLOBAL_BIT] |=> !state_ff.global_irq_en;
  endproperty
  a_control_clear: assert property (p_control_clear) else $error("Global enable not cleared by write."); // [RL20]

  property p_enable_read;
    @(posedge clk) disable iff (reset)
      rd && addr == irq_bank_pkg::ENABLES_OFFSET |=> rdata == $past(state_ff.enables);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("Enable read returned wrong value.");

  property p_unmapped_read;
    @(posedge clk) disable iff (reset)
      rd && addr != irq_bank_pkg::FLAGS_OFFSET && addr != irq_bank_pkg::ENABLES_OFFSET
      && addr != irq_bank_pkg::CONTROL_OFFSET |=> rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read returned data.");

  property p_rdata_idle;
    @(posedge clk) disable iff (reset)
      !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data shown without a read.");

  property p_reset_values;
    @(posedge clk)
      reset |-> state_ff == '0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("State not cleared in reset."); // [RL19]

  property p_mask_block;
    @(posedge clk) disable iff (reset)
      pending == 8'h00 |=> !periph_irq;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("Request without an enabled flag."); // [RL21]

  property p_parallel_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::PARALLEL_BIT] |=> periph_irq;
  endproperty
  a_parallel_allow: assert property (p_parallel_allow) else $error("Parallel port request lost."); // [RL3]

  property p_rx_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::RX_BIT] |=> periph_irq;
  endproperty
  a_rx_allow: assert property (p_rx_allow) else $error("Receive request lost."); // [RL4]

  property p_tx_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::TX_BIT] |=> periph_irq;
  endproperty
  a_tx_allow: assert property (p_tx_allow) else $error("Transmit request lost."); // [RL5]

  property p_sync_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::SYNC_BIT] |=> periph_irq;
  endproperty
  a_sync_allow: assert property (p_sync_allow) else $error("Sync serial request lost."); // [RL21]

  property p_capcmp_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::CAPCMP_BIT] |=> periph_irq;
  endproperty
  a_capcmp_allow: assert property (p_capcmp_allow) else $error("Capture/compare request lost."); // [RL21]

  property p_timer_b_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::TIMER_B_BIT] |=> periph_irq;
  endproperty
  a_timer_b_allow: assert property (p_timer_b_allow) else $error("Timer match request lost."); // [RL6]

  property p_timer_a_allow;
    @(posedge clk) disable iff (reset)
      state_ff.global_irq_en && pending[irq_bank_pkg::TIMER_A_BIT] |=> periph_irq;
  endproperty
  a_timer_a_allow: assert property (p_timer_a_allow) else $error("Overflow request lost."); // [RL7]

  c_irq:     cover property (@(posedge clk) disable iff (reset) $rose(periph_irq));
  c_clear:   cover property (@(posedge clk) disable iff (reset) $fell(state_ff.flags[irq_bank_pkg::TIMER_A_BIT]));
  c_capture: cover property (@(posedge clk) disable iff (reset) $rose(state_ff.flags[irq_bank_pkg::CAPCMP_BIT]));
  c_pwm:     cover property (@(posedge clk) disable iff (reset)
                             capcmp_mode == irq_bank_pkg::CC_PULSE_WIDTH && capcmp_match);
  c_buffers: cover property (@(posedge clk) disable iff (reset) live_flags[irq_bank_pkg::RX_BIT] && periph_irq);

endmodule : peripheral_irq_enable_flag_bank

// *** verilog/irq_bank_pkg.sv ***
/*
  Register map, bit positions and reset values of the peripheral interrupt enable and flag bank.
  Assumes a byte-wide register port and a single core clock domain.
*/
package irq_bank_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] FLAGS_OFFSET   = 8'h0c;
  localparam logic [7:0] ENABLES_OFFSET = 8'h8c;
  // Own register holding the global enable copy at its documented bit.
  localparam logic [7:0] CONTROL_OFFSET = 8'h0b;

  // ==========================================================================
  // Bit positions, shared by the enable and flag bytes, and the global enable bit of the control byte.
  localparam int PARALLEL_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int RX_BIT       = 5;
  localparam int TX_BIT       = 4;
  localparam int SYNC_BIT     = 3;
  localparam int CAPCMP_BIT   = 2;
  localparam int TIMER_B_BIT  = 1;
  localparam int TIMER_A_BIT  = 0;
  localparam int GLOBAL_BIT   = 7;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Capture/compare unit modes.
  typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_PULSE_WIDTH} capcmp_mode_t;

endpackage : irq_bank_pkg

// *** testbench/periph_event_model.sv ***
/*
  Event source model for the peripheral interrupt bank.
  Assumes the bench drives a request vector just after rising edges.
*/
`timescale 1ns/1ps
module periph_event_model (
  // Request vector, one bit per flag position.
  input  wire logic [7:0] req,
  // Events and buffer levels towards the bank.
  output logic            parallel_rw_event,
  output logic            sync_serial_done,
  output logic            capcmp_capture,
  output logic            capcmp_match,
  output logic            timer_b_match,
  output logic            timer_a_overflow,
  output logic            serial_rx_full,
  output logic            serial_tx_empty
);
  // ==========================================================================
  // Each request bit except bit 6 drives the source at the same position.
  // Capture and match share one bit so a stray mode shows up.
  assign parallel_rw_event = req[7];
  assign serial_rx_full    = req[5];
  assign serial_tx_empty   = req[4];
  assign sync_serial_done  = req[3];
  assign capcmp_capture    = req[2];
  assign capcmp_match      = req[2];
  assign timer_b_match     = req[1];
  assign timer_a_overflow  = req[0];
endmodule : periph_event_model

// *** testbench/tb_peripheral_irq_enable_flag_bank.sv ***
/*
  Self-checking bench for the peripheral interrupt bank.
  Assumes the event model beside it and a 50 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_peripheral_irq_enable_flag_bank;
  // ==========================================================================
  // Stimulus and observed signals.
  localparam logic [7:0] FL = irq_bank_pkg::FLAGS_OFFSET;
  localparam logic [7:0] EN = irq_bank_pkg::ENABLES_OFFSET;
  localparam logic [7:0] CT = irq_bank_pkg::CONTROL_OFFSET;
  logic                       clk = 1'b0, reset = 1'b0, wr = 1'b0, rd = 1'b0, irq, irq_lite;
  logic [7:0]                 addr = 8'h00, wdata = 8'h00, rdata, req = 8'h00, d, rdata_lite, d_lite;
  irq_bank_pkg::capcmp_mode_t mode = irq_bank_pkg::CC_CAPTURE;
  logic                       pe, se, cc, cm, tb, ta, rf, te;
  int                         n_errors = 0, checks = 0, cyc = 0;
  int                         bits[7] = '{7, 5, 4, 3, 2, 1, 0};

  // Clock and hang guard.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  periph_event_model u_src (.req(req), .parallel_rw_event(pe), .sync_serial_done(se), .capcmp_capture(cc),
    .capcmp_match(cm), .timer_b_match(tb), .timer_a_overflow(ta), .serial_rx_full(rf), .serial_tx_empty(te));
  peripheral_irq_enable_flag_bank u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .parallel_rw_event(pe), .sync_serial_done(se), .capcmp_capture(cc),
    .capcmp_match(cm), .capcmp_mode(mode), .timer_b_match(tb), .timer_a_overflow(ta),
    .serial_rx_full(rf), .serial_tx_empty(te), .periph_irq(irq));
  // Variant without parallel port and without serial unit, fed the same bus and events.
  peripheral_irq_enable_flag_bank #(.HAS_PARALLEL(1'b0), .HAS_SERIAL(1'b0)) u_dut_lite (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_lite), .parallel_rw_event(pe),
    .sync_serial_done(se), .capcmp_capture(cc), .capcmp_match(cm), .capcmp_mode(mode), .timer_b_match(tb),
    .timer_a_overflow(ta), .serial_rx_full(rf), .serial_tx_empty(te), .periph_irq(irq_lite));

  // ==========================================================================
  // Bus cycles: one-cycle strobes, read data taken in the following cycle.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
    d_lite = rdata_lite;
  endtask : rd_reg
  task automatic pulse(input logic [7:0] v);
    @(posedge clk) req <= v;
    @(posedge clk) req <= 8'h00;
  endtask : pulse

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rd_reg(FL);
    `CHK("flags", 8'h00, d)
    rd_reg(EN);
    `CHK("enables", 8'h00, d)
    wr_reg(8'h55, 8'hff);
    rd_reg(8'h55);
    `CHK("unmapped", 8'h00, d)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_latch;
    pulse(8'h8f);
    rd_reg(FL);
    `CHK("latched", 8'h8f, d)
    `CHK("lite latched", 8'h0f, d_lite)
    `CHK("irq masked", 1'b0, irq)
    wr_reg(FL, 8'h00);
    rd_reg(FL);
    `CHK("cleared", 8'h00, d)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= irq_bank_pkg::capcmp_mode_t'(m);
      pulse(8'h04);
      rd_reg(FL);
      `CHK("capcmp", (m == 1 || m == 2) ? 8'h04 : 8'h00, d)
      wr_reg(FL, 8'h00);
    end
    mode <= irq_bank_pkg::CC_CAPTURE;
    $display("t_latch done");
  endtask : t_latch
  task automatic t_enables;
    wr_reg(CT, 8'h80);
    foreach (bits[i]) begin
      wr_reg(FL, 8'h00);
      wr_reg(EN, 8'h01 << bits[i]);
      @(posedge clk) req <= 8'h01 << bits[i];
      repeat (3) @(posedge clk);
      req <= 8'h00;
      #1 `CHK("irq on", 1'b1, irq)
      `CHK("lite irq on", bits[i] < 4, irq_lite)
      wr_reg(EN, 8'h00);
      repeat (2) @(posedge clk);
      #1 `CHK("irq off", 1'b0, irq)
    end
    wr_reg(EN, 8'h01);
    pulse(8'h01);
    wr_reg(CT, 8'h00);
    repeat (2) @(posedge clk);
    #1 `CHK("irq global off", 1'b0, irq)
    wr_reg(CT, 8'h80);
    repeat (2) @(posedge clk);
    #1 `CHK("irq global on", 1'b1, irq)
    wr_reg(EN, 8'h00);
    $display("t_enables done");
  endtask : t_enables
  task automatic t_serial;
    wr_reg(FL, 8'hbf);
    rd_reg(FL);
    `CHK("flags written", 8'h8f, d)
    @(posedge clk) req <= 8'h30;
    wr_reg(FL, 8'h00);
    rd_reg(FL);
    `CHK("buffer flags", 8'h30, d)
    `CHK("lite buffer flags", 8'h00, d_lite)
    @(posedge clk) req <= 8'h00;
    rd_reg(FL);
    `CHK("buffer flags gone", 8'h00, d)
    wr_reg(EN, 8'hff);
    rd_reg(EN);
    `CHK("enables written", 8'hbf, d)
    wr_reg(EN, 8'h00);
    $display("t_serial done");
  endtask : t_serial
  task automatic t_midreset;
    wr_reg(EN, 8'h0f);
    wr_reg(CT, 8'h80);
    pulse(8'h0f);
    repeat (2) @(posedge clk);
    #1 `CHK("irq before reset", 1'b1, irq)
    @(posedge clk) reset <= 1'b1;
    #1 `CHK("irq in reset", 1'b0, irq)
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_reg(FL);
    `CHK("flags after reset", 8'h00, d)
    rd_reg(EN);
    `CHK("enables after reset", 8'h00, d)
    rd_reg(CT);
    `CHK("control after reset", 8'h00, d)
    `CHK("irq after reset", 1'b0, irq)
    $display("t_midreset done");
  endtask : t_midreset

  // Verdict and end of run.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence after eight cycles of reset.
  initial begin
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_latch();
    t_enables();
    t_serial();
    t_midreset();
    tally_and_finish();
  end
endmodule : tb_peripheral_irq_enable_flag_bank
